// ---- common/orient_pkg.sv ----
// Purpose: shared types and constants for the track orientation tracker
// Assumes: one 200 MHz clock, drive boundary marks already in byte framing
// Notes:   field and zone codes are dense; zone B only occurs in front of a count
package orient_pkg;

   // clock period in ns, kept for anyone converting times to cycles
   localparam int CLK_PERIOD_NS = 5;

   // constant gap lengths in bytes: ones ahead of count, zeros ahead of home address
   localparam logic [4:0] GAP_A_COUNT_BYTES = 5'h0C;
   localparam logic [4:0] GAP_A_HOME_BYTES  = 5'h1C;
   // variable gap between records, in tenths of a percent of the track
   localparam logic [5:0] GAP_B_PERMILLE    = 6'h31;

   // opcodes; bit 7 is the multi-track flag and is masked before decode, except for no-op and IPL read, which are compared whole
   localparam logic [7:0] OPC_MT_MASK   = 8'h7F;
   localparam logic [7:0] OPC_NOOP      = 8'h03;
   localparam logic [7:0] OPC_READ_IPL  = 8'h02;
   localparam logic [7:0] OPC_READ_CNT  = 8'h12;
   localparam logic [7:0] OPC_READ_HOME = 8'h1A;
   localparam logic [7:0] OPC_READ_DATA = 8'h06;
   localparam logic [7:0] OPC_SRCH_ID   = 8'h31;
   localparam logic [7:0] OPC_WR_KD     = 8'h0D;
   localparam logic [7:0] OPC_WR_HOME   = 8'h19;
   localparam logic [7:0] OPC_SRCH_HOME = 8'h39;

   // reset values of the held unit control word bytes
   localparam logic [7:0] FLAG_RESET    = 8'h00;
   localparam logic [7:0] OPC_RESET     = 8'h00;
   // sense byte 1 bit position of the invalid-sequence flag
   localparam int         SENSE1_INV_SEQ_BIT = 3;

   typedef enum logic [1:0] {
      FLD_H = 2'h0,                      // home address area
      FLD_C = 2'h1,                      // count area
      FLD_K = 2'h2,                      // key area
      FLD_D = 2'h3                       // data area
   } field_e;

   typedef enum logic [2:0] {
      ZN_A = 3'h0,                       // constant gap
      ZN_B = 3'h1,                       // variable gap between records
      ZN_1 = 3'h2,                       // pre-record gap with address marker
      ZN_2 = 3'h3,                       // record
      ZN_3 = 3'h4,                       // cyclic check bytes
      ZN_4 = 3'h5                        // post-record gap
   } zone_e;

   typedef struct packed {
      logic   valid;                     // low means reset condition
      field_e field;
      zone_e  zone;
   } orient_s;

   typedef struct packed {
      logic [7:0] opcode;                // channel operation code
      logic [7:0] flags;                 // unit control word flag byte
   } cmd_s;

   typedef enum logic [3:0] {
      CL_OTHER  = 4'h0,
      CL_IPL    = 4'h1,
      CL_RDCNT  = 4'h2,
      CL_RDHOME = 4'h3,
      CL_WRHOME = 4'h4,
      CL_SRHOME = 4'h5,
      CL_SRID   = 4'h6,
      CL_WRKD   = 4'h7,
      CL_RDDATA = 4'h8,
      CL_NOOP   = 4'h9
   } cmd_class_e;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,                  // ready for a command
      ST_SEEK = 3'b010,                  // waiting for the start orientation
      ST_RUN  = 3'b100                   // waiting for the end orientation
   } trk_state_e;

endpackage : orient_pkg

// ---- logic/pin_filter.sv ----
// Purpose: bring drive pins into the clock domain and filter them
// Assumes: pins are asynchronous levels from the drive
// Notes:   a change is taken only once stages one and two agree
`timescale 1ns/1ps
module pin_filter #(
   parameter int WIDTH = 3                       // number of pins
) (
   input  wire logic             clk,            // system clock
   input  wire logic             rst_n,          // async reset, active low
   input  wire logic [WIDTH-1:0] pin_in,         // raw pins
   output logic      [WIDTH-1:0] level_out,      // filtered level
   output logic      [WIDTH-1:0] rise_out        // one-cycle pulse on filtered rise
);

   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_pin
         logic [2:0] sync_reg;                   // stage 0 is read only by stage 1
         logic [2:0] sync_next;
         logic       lvl_reg;                    // filtered level
         logic       lvl_next;

         // shift and accept the level when the two later stages agree
         always_comb begin
            sync_next = {sync_reg[1:0], pin_in[gi]};
            lvl_next  = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : lvl_reg;
         end

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               sync_reg <= 3'h0;
               lvl_reg  <= 1'b0;
            end else begin
               sync_reg <= sync_next;
               lvl_reg  <= lvl_next;
            end
         end

         assign level_out[gi] = lvl_reg;
         assign rise_out[gi]  = lvl_next & ~lvl_reg;
      end
   endgenerate

endmodule : pin_filter

// ---- logic/track_orient.sv ----
// Purpose: track head orientation on a disk track and check command start states
// Assumes: drive toggles zone_mark_pin at every zone boundary but the one at index, pulses index_pin at index
// Notes:   a command that cannot reach its start state waits a revolution, by design
//
// Contract
// - orientation is field plus zone A, B or one to four
// - gap A: 12 ones count, 28 zeros home
// - variable gap B is its own zone
// - index puts orientation at home address start
// - IPL read runs count 1 to data 4
// - lone search ID runs count 1 to 4
// - lone read count runs count 1 to 4
// - read home runs home gap to home 4
// - write home runs home gap to home 4
// - search home runs home gap to home 4
// - write key data only after equal search
// - no-op returns tracker to reset condition
// - hold flag byte and opcode of command
// - bad sequence sets invalid-sequence sense bit
`timescale 1ns/1ps
module track_orient
   import orient_pkg::*;
(
   input  wire logic       clk,                  // 200 MHz system clock
   input  wire logic       rst_n,                // async reset, active low
   input  wire logic       cmd_valid,            // channel offers a command
   input  wire cmd_s       cmd,                  // opcode and flag byte
   output logic            cmd_ready,            // tracker takes the command
   output logic            cmd_reject,           // pulse: sequence invalid
   output logic            cmd_done,             // pulse: end orientation reached
   input  wire logic       srch_equal,           // channel: last compare was equal
   input  wire logic       sense_clear,          // channel: clear sense flag
   output logic            inv_seq,              // sense byte 1 invalid-sequence
   output orient_s         orient,               // current field and zone
   output logic [4:0]      gap_bytes,            // expected constant gap length
   output logic [7:0]      file_flag_holding_reg,   // held flag byte
   output logic [7:0]      file_opcode_holding_reg, // held opcode
   input  wire logic       index_pin,            // drive index mark
   input  wire logic       zone_mark_pin,        // drive toggles per zone boundary
   input  wire logic       key_absent_pin        // drive: record has no key field
);

   ////////////////////////////////////////////////////////////////////////////
   // drive pins

   logic [2:0] pin_lvl;                          // filtered levels
   logic [2:0] pin_rise;                         // filtered rising pulses
   logic       mark_reg;                         // last filtered zone mark level
   logic       idx_evt;                          // index seen
   logic       step_evt;                         // one zone boundary passed

   pin_filter #(.WIDTH(3)) u_pins (
      .clk       (clk),
      .rst_n     (rst_n),
      .pin_in    ({key_absent_pin, zone_mark_pin, index_pin}),
      .level_out (pin_lvl),
      .rise_out  (pin_rise)
   );

   assign idx_evt  = pin_rise[0];
   assign step_evt = pin_lvl[1] ^ mark_reg;      // either edge is a boundary

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // next zone in track order; only count carries the variable gap
   function automatic orient_s step_fn(input orient_s o, input logic no_key);
      orient_s r;
      r = o;
      unique case (o.zone)
         ZN_B: r.zone = ZN_A;
         ZN_A: r.zone = ZN_1;
         ZN_1: r.zone = ZN_2;
         ZN_2: r.zone = ZN_3;
         ZN_3: r.zone = ZN_4;
         default: begin                          // zone 4 ends the field
            r.zone = ZN_1;
            unique case (o.field)
               FLD_H: r.field = FLD_C;           // track descriptor count follows
               FLD_C: r.field = no_key ? FLD_D : FLD_K;
               FLD_K: r.field = FLD_D;
               FLD_D: begin
                  r.field = FLD_C;
                  r.zone  = ZN_B;
               end
            endcase
         end
      endcase
      return r;
   endfunction : step_fn

   function automatic orient_s mk(input field_e f, input zone_e z);
      orient_s r;
      r.valid = 1'b1;
      r.field = f;
      r.zone  = z;
      return r;
   endfunction : mk

   function automatic cmd_class_e class_fn(input logic [7:0] op);
      logic [7:0] m;
      m = op & OPC_MT_MASK;
      if (op == OPC_NOOP) return CL_NOOP;
      if (op == OPC_READ_IPL) return CL_IPL;
      if (m == OPC_READ_CNT) return CL_RDCNT;
      if (m == OPC_READ_HOME) return CL_RDHOME;
      if (m == OPC_WR_HOME) return CL_WRHOME;
      if (m == OPC_SRCH_HOME) return CL_SRHOME;
      if (m == OPC_SRCH_ID) return CL_SRID;
      if (m == OPC_WR_KD) return CL_WRKD;
      if (m == OPC_READ_DATA) return CL_RDDATA;
      return CL_OTHER;
   endfunction : class_fn

   ////////////////////////////////////////////////////////////////////////////
   // command sequencing

   trk_state_e state_reg, state_next;            // command state
   cmd_class_e cls_reg, cls_next;                // class of running command
   cmd_class_e prev_reg, prev_next;              // class of last finished command
   logic       eq_reg, eq_next;                  // last search compared equal
   orient_s    start_reg, start_next;            // start orientation wanted
   orient_s    end_reg, end_next;                // end orientation wanted
   orient_s    orient_reg, orient_next;          // head orientation
   logic [7:0] flag_reg, flag_next;              // held flag byte
   logic [7:0] opc_reg, opc_next;                // held opcode
   logic       inv_reg, inv_next;                // invalid-sequence sense flag
   logic [4:0] gap_reg, gap_next;                // expected gap A length
   cmd_class_e cls_in;                           // decoded incoming class
   logic       take;                             // command taken this cycle
   logic       chained;                          // predecessor was an ID search

   assign cls_in    = class_fn(cmd.opcode);
   assign cmd_ready = (state_reg == ST_IDLE);
   assign take      = cmd_valid & cmd_ready;
   assign chained   = (prev_reg == CL_SRID);
   assign cmd_reject = take & (cls_in == CL_WRKD) & ~(chained & eq_reg);
   assign cmd_done  = (state_reg == ST_RUN) & (orient_reg == end_reg);

   // decode start and end states, run the wait states
   always_comb begin
      state_next = state_reg;
      cls_next   = cls_reg;
      prev_next  = prev_reg;
      eq_next    = eq_reg;
      start_next = start_reg;
      end_next   = end_reg;
      flag_next  = flag_reg;
      opc_next   = opc_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (take) begin
               flag_next = cmd.flags;
               opc_next  = cmd.opcode;
               cls_next  = cls_in;
               state_next = ST_SEEK;
               unique case (cls_in)
                  CL_IPL: begin
                     start_next = mk(FLD_C, ZN_1);
                     end_next   = mk(FLD_D, ZN_4);
                  end
                  CL_SRID, CL_RDCNT: begin
                     start_next = mk(FLD_C, ZN_1);
                     end_next   = mk(FLD_C, ZN_4);
                  end
                  CL_RDHOME, CL_WRHOME, CL_SRHOME: begin
                     start_next = mk(FLD_H, ZN_A);
                     end_next   = mk(FLD_H, ZN_4);
                  end
                  CL_WRKD, CL_RDDATA: begin
                     start_next = chained ? mk(FLD_C, ZN_4) : mk(FLD_C, ZN_1);
                     end_next   = mk(FLD_D, ZN_4);
                  end
                  default: begin                 // no-op and others move no head
                     state_next = ST_IDLE;
                     prev_next  = cls_in;
                  end
               endcase
               if (cmd_reject) begin
                  state_next = ST_IDLE;
                  prev_next  = CL_OTHER;
               end
            end
         end
         ST_SEEK: begin
            if (orient_reg == start_reg) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (cmd_done) begin
               state_next = ST_IDLE;
               prev_next  = cls_reg;
               eq_next    = (cls_reg == CL_SRID) & srch_equal;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         cls_reg   <= CL_OTHER;
         prev_reg  <= CL_OTHER;
         eq_reg    <= 1'b0;
         start_reg <= '0;
         end_reg   <= '0;
         flag_reg  <= FLAG_RESET;
         opc_reg   <= OPC_RESET;
      end else begin
         state_reg <= state_next;
         cls_reg   <= cls_next;
         prev_reg  <= prev_next;
         eq_reg    <= eq_next;
         start_reg <= start_next;
         end_reg   <= end_next;
         flag_reg  <= flag_next;
         opc_reg   <= opc_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // orientation and sense

   // index wins over a boundary; a no-op drops back to the reset condition
   always_comb begin
      orient_next = orient_reg;
      if (take & (cls_in == CL_NOOP)) begin
         orient_next = '0;
      end else if (idx_evt) begin
         orient_next = mk(FLD_H, ZN_A);
      end else if (step_evt & orient_reg.valid) begin
         orient_next = step_fn(orient_reg, pin_lvl[2]);
      end
      gap_next = (orient_next.field == FLD_H) ? GAP_A_HOME_BYTES : GAP_A_COUNT_BYTES;
      // a new fault wins over a clear in the same cycle
      inv_next = cmd_reject | (inv_reg & ~sense_clear);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         orient_reg <= '0;
         mark_reg   <= 1'b0;
         inv_reg    <= 1'b0;
         gap_reg    <= GAP_A_COUNT_BYTES;
      end else begin
         orient_reg <= orient_next;
         mark_reg   <= pin_lvl[1];
         inv_reg    <= inv_next;
         gap_reg    <= gap_next;
      end
   end

   assign orient                  = orient_reg;
   assign inv_seq                 = inv_reg;
   assign gap_bytes               = gap_reg;
   assign file_flag_holding_reg   = flag_reg;
   assign file_opcode_holding_reg = opc_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   home_gap_len_a: assert property (orient_reg.valid && orient_reg.field == FLD_H
      |-> gap_bytes == GAP_A_HOME_BYTES) else $error("home gap length wrong");
   index_home_a: assert property (idx_evt && !(take && cls_in == CL_NOOP)
      |=> orient_reg == mk(FLD_H, ZN_A)) else $error("index did not restart");
   ipl_end_a: assert property (cmd_done && cls_reg == CL_IPL
      |-> orient_reg == mk(FLD_D, ZN_4)) else $error("ipl end state wrong");
   srid_end_a: assert property (cmd_done && (cls_reg == CL_SRID || cls_reg == CL_RDCNT)
      |-> orient_reg == mk(FLD_C, ZN_4)) else $error("count end state wrong");
   home_run_a: assert property (state_reg == ST_SEEK && cls_reg inside {CL_RDHOME,
      CL_WRHOME, CL_SRHOME} && orient_reg == mk(FLD_H, ZN_A) |=> state_reg == ST_RUN
      ##0 end_reg == mk(FLD_H, ZN_4)) else $error("home command did not start");
   wrkd_order_a: assert property (take && cls_in == CL_WRKD && !(chained && eq_reg)
      |-> cmd_reject ##1 (inv_seq && state_reg == ST_IDLE)) else $error("write not refused");
   noop_reset_a: assert property (take && cls_in == CL_NOOP
      |=> !orient_reg.valid && state_reg == ST_IDLE) else $error("no-op kept orientation");
   opc_hold_a: assert property (take |=> opc_reg == $past(cmd.opcode)
      && file_flag_holding_reg == $past(cmd.flags)) else $error("opcode not held");
   inv_set_a: assert property (cmd_reject |=> inv_seq [*2] or (inv_seq ##1 1'b1))
      else $error("invalid sequence not flagged");
   home_to_count_a: assert property (step_evt && !idx_evt && !take
      && orient_reg == mk(FLD_H, ZN_4) |=> orient_reg == mk(FLD_C, ZN_1))
      else $error("home field not followed by count");

endmodule : track_orient

// ---- dv/drive_model.sv ----
// Purpose: behavioural disk drive that spins one track past the tracker
// Assumes: every zone lasts ZONE_LEN clocks, REC_N records follow the home address
// Notes:   exp_o is where the head is; settled once the tracker has had time to follow
`timescale 1ns/1ps
module drive_model
   import orient_pkg::*;
#(
   parameter int ZONE_LEN = 12,                  // clocks per zone
   parameter int REC_N    = 2                    // records per track
) (
   input  wire logic clk,                        // system clock
   input  wire logic rst_n,                      // async reset, active low
   input  wire logic run,                        // spin the track
   input  wire logic key_req,                    // next record is written without key
   output logic      index_pin,                  // index mark
   output logic      zone_mark_pin,              // toggles at every zone boundary but the one at index
   output logic      key_absent_pin,             // current record has no key
   output orient_s   exp_o,                      // present head position
   output logic      settled                     // tracker had time to follow
);
   int cnt;                                      // clocks spent in this zone
   int rec;                                      // record number on the track

   // pins pass a 3-flop filter, so give 5 clocks before trusting the tracker
   assign settled = exp_o.valid && (cnt >= 5);

   ////////////////////////////////////////////////////////////////////////////////
   // the head moves one zone per ZONE_LEN clocks, in recorded order
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt            <= 0;
         rec            <= 0;
         index_pin      <= 1'b0;
         zone_mark_pin  <= 1'b0;
         key_absent_pin <= 1'b0;
         exp_o          <= '0;
      end else if (run) begin
         cnt <= cnt + 1;
         // index pulse of four clocks, long enough for the filter
         if (cnt == 3) index_pin <= 1'b0;
         if (!exp_o.valid || (cnt == ZONE_LEN - 1 && rec == REC_N - 1 &&
                              exp_o.field == FLD_D && exp_o.zone == ZN_4)) begin
            index_pin <= 1'b1;
            exp_o     <= '{1'b1, FLD_H, ZN_A};
            rec       <= 0;
            cnt       <= 0;
         end else if (cnt == ZONE_LEN - 1) begin
            cnt           <= 0;
            zone_mark_pin <= ~zone_mark_pin;
            case (exp_o.zone)
               ZN_A: exp_o.zone <= ZN_1;
               ZN_B: exp_o.zone <= ZN_A;
               ZN_4: begin
                  exp_o.zone <= ZN_1;
                  case (exp_o.field)
                     FLD_H: begin
                        exp_o.field    <= FLD_C;
                        key_absent_pin <= key_req;
                     end
                     FLD_C: exp_o.field <= key_absent_pin ? FLD_D : FLD_K;
                     FLD_K: exp_o.field <= FLD_D;
                     default: begin
                        // next record opens with the variable gap
                        exp_o          <= '{1'b1, FLD_C, ZN_B};
                        rec            <= rec + 1;
                        key_absent_pin <= key_req;
                     end
                  endcase
               end
               default: exp_o.zone <= zone_e'(exp_o.zone + 3'h1);
            endcase
         end
      end
   end
endmodule : drive_model

// ---- dv/testbench.sv ----
// Purpose: self-checking bench for the track orientation tracker
// Assumes: drive model spins the track; commands are driven at the falling edge
// Notes:   random flags, multi-track bits and key presence from a fixed xorshift seed
`timescale 1ns/1ps
module testbench
   import orient_pkg::*;
   ;
   logic        clk, rst_n, cmd_valid, cmd_ready, cmd_reject, cmd_done;  // command port
   logic        srch_equal, sense_clear, inv_seq;  // channel side
   cmd_s        cmd;                             // opcode and flags
   orient_s     orient, exp_o;                   // tracker and drive positions
   logic [4:0]  gap_bytes;                       // expected gap length
   logic [7:0]  flag_q, opc_q;                   // holding registers
   logic        index_pin, zone_mark_pin, key_absent_pin;  // drive pins
   logic        run, key_req, settled, exp_valid, hold_mon, idx_prev, after_srid;  // bench control
   logic [31:0] seed;                            // xorshift state
   logic [7:0]  lone [6];                        // commands needing no predecessor
   int          n_errors, tests_run, i;          // counters

   track_orient dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready(cmd_ready), .cmd_reject(cmd_reject), .cmd_done(cmd_done),
      .srch_equal(srch_equal), .sense_clear(sense_clear), .inv_seq(inv_seq),
      .orient(orient), .gap_bytes(gap_bytes), .file_flag_holding_reg(flag_q),
      .file_opcode_holding_reg(opc_q), .index_pin(index_pin),
      .zone_mark_pin(zone_mark_pin), .key_absent_pin(key_absent_pin));
   drive_model drv (.clk(clk), .rst_n(rst_n), .run(run), .key_req(key_req),
      .index_pin(index_pin), .zone_mark_pin(zone_mark_pin),
      .key_absent_pin(key_absent_pin), .exp_o(exp_o), .settled(settled));

   ////////////////////////////////////////////////////////////////////////////////
   // helpers: random numbers, expectations, comparisons
   task automatic next_rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
   endtask : next_rnd

   // start orientation each command must wait for
   function automatic orient_s start_of(input logic [7:0] op, input logic chain);
      case (op & OPC_MT_MASK)
         OPC_WR_KD, OPC_READ_DATA: begin
            if (chain) return '{1'b1, FLD_C, ZN_4};
            return '{1'b1, FLD_C, ZN_1};
         end
         OPC_READ_IPL, OPC_SRCH_ID, OPC_READ_CNT: return '{1'b1, FLD_C, ZN_1};
         default:                                return '{1'b1, FLD_H, ZN_A};
      endcase
   endfunction : start_of

   // orientation each command leaves behind
   function automatic orient_s end_of(input logic [7:0] op);
      case (op & OPC_MT_MASK)
         OPC_READ_IPL, OPC_WR_KD, OPC_READ_DATA: return '{1'b1, FLD_D, ZN_4};
         OPC_SRCH_ID, OPC_READ_CNT: return '{1'b1, FLD_C, ZN_4};
         default:                  return '{1'b1, FLD_H, ZN_4};
      endcase
   endfunction : end_of

   task automatic miss(input string what);
      n_errors++;
      $display("mismatch at %0t: %s", $time, what);
   endtask : miss

   task automatic check_orient(input orient_s got, input orient_s exp);
      tests_run++;
      if (got !== exp) miss($sformatf("orient %h, expected %h", got, exp));
   endtask : check_orient

   task automatic check_flag(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) miss($sformatf("flag %b, expected %b", got, exp));
   endtask : check_flag

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) miss($sformatf("byte %h, expected %h", got, exp));
   endtask : check_byte

   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop

   // issue one command at a falling edge; wait for done unless refused or no-op
   task automatic run_cmd(input logic [7:0] op, input logic rej);
      logic [7:0] fl;
      logic       seen;
      int         n;
      seen = 1'b0;
      n    = 0;
      next_rnd();
      fl      = seed[7:0];
      key_req = seed[8];
      @(negedge clk);
      while (cmd_ready !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      check_flag(cmd_ready, 1'b1);
      cmd_valid = 1'b1;
      cmd       = '{op, fl};
      #1;
      check_flag(cmd_reject, rej);
      @(negedge clk);
      cmd_valid = 1'b0;
      check_byte(opc_q, op);
      check_byte(flag_q, fl);
      if (rej) check_flag(inv_seq, 1'b1);
      if (!rej && op !== OPC_NOOP) begin
         n = 0;
         while (cmd_done !== 1'b1 && n < 3000) begin
            if (orient === start_of(op, after_srid)) seen = 1'b1;
            @(negedge clk);
            n++;
         end
         check_flag(seen, 1'b1);
         check_orient(orient, end_of(op));
      end
      after_srid = ((op & OPC_MT_MASK) == OPC_SRCH_ID);
   endtask : run_cmd

   ////////////////////////////////////////////////////////////////////////////////
   // clock, hang guard and continuous position monitor
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // about 30 commands of one revolution each fit well inside this ceiling
   initial begin
      repeat (40000) @(posedge clk);
      miss("run did not finish");
      report_and_stop();
   end

   always @(negedge clk) begin
      if (index_pin && !idx_prev) exp_valid = 1'b1;
      idx_prev = index_pin;
      if (rst_n && settled && !hold_mon) begin
         if (exp_valid) begin
            check_orient(orient, exp_o);
            check_byte({3'h0, gap_bytes}, {3'h0, (exp_o.field == FLD_H) ?
               GAP_A_HOME_BYTES : GAP_A_COUNT_BYTES});
         end else
            check_flag(orient.valid, 1'b0);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {rst_n, cmd_valid, srch_equal, sense_clear, run, key_req} = '0;
      {exp_valid, hold_mon, idx_prev, after_srid} = '0;
      cmd       = '0;
      seed      = 32'h2277;
      n_errors  = 0;
      tests_run = 0;
      lone      = '{OPC_READ_IPL, OPC_SRCH_ID, OPC_READ_CNT, OPC_READ_HOME,
                    OPC_WR_HOME, OPC_SRCH_HOME};
      repeat (10) @(negedge clk);
      check_orient(orient, '0);
      check_byte(opc_q, OPC_RESET);
      check_flag(inv_seq, 1'b0);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      run = 1'b1;
      // every lone command, multi-track bit set at random except on load
      for (i = 0; i < 6; i++) begin
         next_rnd();
         run_cmd(lone[i] | {(i > 0) & seed[9], 7'h00}, 1'b0);
      end
      // equal search chained into write key and data
      srch_equal = 1'b1;
      run_cmd(OPC_SRCH_ID, 1'b0);
      run_cmd(OPC_WR_KD, 1'b0);
      srch_equal = 1'b0;
      // write key and data after a read count is refused
      run_cmd(OPC_READ_CNT, 1'b0);
      run_cmd(OPC_WR_KD, 1'b1);
      run_cmd(OPC_READ_HOME, 1'b0);
      check_flag(inv_seq, 1'b1);
      sense_clear = 1'b1;
      @(negedge clk);
      sense_clear = 1'b0;
      @(negedge clk);
      check_flag(inv_seq, 1'b0);
      // an unequal search does not allow the write either
      run_cmd(OPC_SRCH_ID, 1'b0);
      run_cmd(OPC_WR_KD, 1'b1);
      // read data after a search starts at count 4, alone at count 1
      run_cmd(OPC_SRCH_ID, 1'b0);
      run_cmd(OPC_READ_DATA, 1'b0);
      run_cmd(OPC_READ_DATA, 1'b0);
      // no-op drops the tracker to reset condition until the next index
      run_cmd(OPC_READ_CNT, 1'b0);
      hold_mon = 1'b1;
      run_cmd(OPC_NOOP, 1'b0);
      exp_valid = 1'b0;
      @(negedge clk);
      check_flag(orient.valid, 1'b0);
      check_flag(cmd_ready, 1'b1);
      hold_mon = 1'b0;
      while (!exp_valid) @(negedge clk);
      // random mix of lone commands
      for (i = 0; i < 12; i++) begin
         next_rnd();
         run_cmd(lone[seed[18:16] % 6], 1'b0);
      end
      report_and_stop();
   end
endmodule : testbench
